// ---- src/uidpt_map.svh ----
// constants for the unique id and parameter table query logic
// assumes a 100 MHz system clock that oversamples the serial link pins
//
// Behaviour
// (R1) opcode 4BH, four dummy bytes, 128-bit id
// (R2) id bits launched on falling serial clock
// (R3) id is fixed and never writable
// (R4) opcode 5AH, 3-byte address msb first, dummy
// (R5) opcode, address, dummy sampled on rising edge
// (R6) table data out on falling edges, full rate
// (R7) any table byte may start a read
// (R8) address advances by one per output byte
// (R9) past highest address wrap to zero, continue
// (R10) chip select high ends the read anytime
// (R11) table read refused while a cycle runs
// (R12) bytes 07H, 0FH, 17H always read FFH
// (R13) header lengths: 09H at 0BH, 03H at 13H
// (R14) pointers: 30H at 0CH, 60H at 14H
// (R15) byte 08H reads 00H
// (R16) byte 10H returns the 8-bit maker code
// (R17) byte 30H bits 1:0 read 01b
// (R18) byte 30H bit 2 reads 1b
// (R19) byte 30H bit 3 reads 0b
// (R20) chip select high means standby
// (R21) table read accepted during suspend
// (R22) serial output released unless shifting data
// (R23) early deselect aborts without side effect
`ifndef UIDPT_MAP_SVH
`define UIDPT_MAP_SVH

// ----------------------------------------------------------------
// opcodes and phase lengths in serial clock bits
// ----------------------------------------------------------------
`define UIDPT_OP_UID          8'h4B
`define UIDPT_OP_TABLE        8'h5A
`define UIDPT_OP_LAST_BIT     8'h07
`define UIDPT_UID_DUMMY_LAST  8'h1F
`define UIDPT_ADDR_LAST_BIT   8'h17
`define UIDPT_PT_DUMMY_LAST   8'h07
`define UIDPT_UID_BITS        8'h80

// ----------------------------------------------------------------
// link timing: half period of the fastest serial clock in cycles
// ----------------------------------------------------------------
`define UIDPT_SYS_CLK_NS      10
`define UIDPT_SCK_PERIOD_NS   80
`define UIDPT_SCK_HALF_CYC    ((`UIDPT_SCK_PERIOD_NS / 2) / `UIDPT_SYS_CLK_NS)

// ----------------------------------------------------------------
// table layout and fixed header fields
// ----------------------------------------------------------------
`define UIDPT_TABLE_AW        7
`define UIDPT_UNUSED_BYTE     8'hFF
`define UIDPT_STD_ID          8'h00
`define UIDPT_STD_LEN         8'h09
`define UIDPT_VND_LEN         8'h03
`define UIDPT_STD_PTR         8'h30
`define UIDPT_VND_PTR         8'h60
`define UIDPT_ERASE_4K        2'b01
`define UIDPT_WR_GRAN_64      1'b1
`define UIDPT_VOLATILE_SR     1'b0
`define UIDPT_WREN_SEL        1'b0
`define UIDPT_BYTE30_UNUSED   3'b111

`endif

// ---- src/uidpt_pkg.sv ----
// types shared by the unique id and parameter table query logic
// assumes the constants header is included where numbers are needed
package uidpt_pkg;

    // ------------------------------------------------------------
    // serial link pins as seen by the device
    // ------------------------------------------------------------
    typedef struct packed {
        logic cs_n;   // chip select, low selects
        logic sck;    // serial clock from the host
        logic si;     // serial data in
    } uidpt_pins_t;

    // ------------------------------------------------------------
    // command phases while selected
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_OPCODE,
        ST_UID_DUMMY,
        ST_ADDR,
        ST_PT_DUMMY,
        ST_UID_OUT,
        ST_PT_OUT,
        ST_IGNORE
    } uidpt_state_t;

endpackage

// ---- src/uidpt_top.sv ----
// serial query logic: unique id read and parameter table read
// assumes serial pins arrive asynchronously and are oversampled at
// least four system clocks per serial clock half period
// chip select high is the only abort; no command writes state
`timescale 1ns/1ns
`include "uidpt_map.svh"

module uidpt_top #(
    // arbitrary id, stands in for the factory value
    parameter logic [127:0] UNIQUE_ID = 128'h0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2_E1F0,
    // arbitrary maker code
    parameter logic [7:0]   MAKER_ID  = 8'hA5,
    // table address width; highest address wraps to zero
    parameter int           TABLE_AW  = `UIDPT_TABLE_AW
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rstn,
    // serial link pins
    input  wire uidpt_pkg::uidpt_pins_t link_pins,
    // status of the array engine, same clock domain
    // no synchroniser: both come from logic on clk
    input  wire logic                  cycle_busy,
    input  wire logic                  op_suspended,
    // serial data out with its enable
    output logic                       so,
    output logic                       so_oe
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    // link side
    uidpt_pkg::uidpt_pins_t pins_meta_q;   // first synchroniser stage
    uidpt_pkg::uidpt_pins_t pins_sync_q;   // second synchroniser stage
    logic                   sck_prev_q;    // delayed clock for edges
    logic                   sck_rise;      // host rising edge seen
    logic                   sck_fall;      // host falling edge seen
    logic                   selected;      // chip select active

    // command decode
    uidpt_pkg::uidpt_state_t state_q;      // command phase
    logic [7:0]             cnt_q;         // bits done in the phase
    logic [7:0]             shift_q;       // opcode shift register
    logic [7:0]             opcode;        // opcode incl. last bit

    // table and output
    logic [TABLE_AW-1:0]    tbl_idx_q;     // table byte address
    logic [7:0]             tbl_byte;      // byte at tbl_idx_q
    logic                   table_ok;      // table read allowed
    logic                   so_q;          // output data flop
    logic                   so_oe_q;       // output enable flop

    // ------------------------------------------------------------
    // pin synchroniser and edge detection
    // ------------------------------------------------------------
    // two stages before any logic; idle values are deselected
    // the pins move as one word, so they keep their order
    // and si is long settled when a rise shows
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pins_meta_q <= 3'h4;
            pins_sync_q <= 3'h4;
        end else begin
            pins_meta_q <= link_pins;
            pins_sync_q <= pins_meta_q;
        end
    end

    // third flop only feeds the edge detector
    // resets low like an idle clock: no false edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sck_prev_q <= 1'b0;
        end else begin
            sck_prev_q <= pins_sync_q.sck;
        end
    end

    // each edge pulse lasts exactly one clock
    // cs, sck and si share the same latency, so si is still valid
    assign sck_rise = pins_sync_q.sck & ~sck_prev_q;   // R5
    assign sck_fall = ~pins_sync_q.sck & sck_prev_q;   // R2
    assign selected = ~pins_sync_q.cs_n;
    // opcode includes the bit of this rise
    assign opcode   = {shift_q[6:0], pins_sync_q.si};

    // a running cycle refuses the read unless it is suspended
    // looked at only in the opcode decode
    assign table_ok = ~cycle_busy | op_suspended;   // R11 R21

    // ------------------------------------------------------------
    // opcode shift register
    // ------------------------------------------------------------
    // cleared on deselect: a cut opcode leaves nothing
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            shift_q <= 8'h00;
        end else if (!selected) begin
            shift_q <= 8'h00;
        end else if (sck_rise && state_q == uidpt_pkg::ST_OPCODE) begin
            shift_q <= opcode;   // R5
        end
    end

    // ------------------------------------------------------------
    // command phase machine
    // ------------------------------------------------------------
    // deselect always lands in standby, waiting for an opcode;
    // nothing is committed before the data phase, so an early
    // deselect leaves no trace
    // counts are serial bits, cleared per phase
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= uidpt_pkg::ST_OPCODE;
            cnt_q   <= 8'h00;
        end else if (!selected) begin
            state_q <= uidpt_pkg::ST_OPCODE;   // R20 R23 R10
            cnt_q   <= 8'h00;
        end else begin
            unique case (state_q)
                uidpt_pkg::ST_OPCODE: begin
                    if (sck_rise) begin
                        if (cnt_q == `UIDPT_OP_LAST_BIT) begin
                            cnt_q <= 8'h00;
                            // decode on the eighth rising edge
                            if (opcode == `UIDPT_OP_UID) begin
                                state_q <= uidpt_pkg::ST_UID_DUMMY;   // R1
                            end else if (opcode == `UIDPT_OP_TABLE && table_ok) begin
                                // busy refuses only the table read
                                state_q <= uidpt_pkg::ST_ADDR;   // R4 R21
                            end else begin
                                // unknown or refused: quiet
                                state_q <= uidpt_pkg::ST_IGNORE;   // R11
                            end
                        end else begin
                            cnt_q <= cnt_q + 8'h01;
                        end
                    end
                end

                uidpt_pkg::ST_UID_DUMMY: begin
                    // four dummy bytes before the id
                    // dummy bits are counted, never checked
                    if (sck_rise) begin
                        if (cnt_q == `UIDPT_UID_DUMMY_LAST) begin
                            cnt_q   <= 8'h00;
                            state_q <= uidpt_pkg::ST_UID_OUT;   // R1
                        end else begin
                            cnt_q <= cnt_q + 8'h01;
                        end
                    end
                end

                uidpt_pkg::ST_ADDR: begin
                    // three address bytes, msb first
                    // only the low table bits are kept
                    if (sck_rise) begin
                        if (cnt_q == `UIDPT_ADDR_LAST_BIT) begin
                            cnt_q   <= 8'h00;
                            state_q <= uidpt_pkg::ST_PT_DUMMY;   // R4
                        end else begin
                            cnt_q <= cnt_q + 8'h01;
                        end
                    end
                end

                uidpt_pkg::ST_PT_DUMMY: begin
                    // one dummy byte before table data
                    if (sck_rise) begin
                        if (cnt_q == `UIDPT_PT_DUMMY_LAST) begin
                            cnt_q   <= 8'h00;
                            state_q <= uidpt_pkg::ST_PT_OUT;   // R4
                        end else begin
                            cnt_q <= cnt_q + 8'h01;
                        end
                    end
                end

                uidpt_pkg::ST_UID_OUT: begin
                    // count launched bits; stop after the last one
                    // the fall after bit zero releases so
                    if (sck_fall) begin
                        if (cnt_q == `UIDPT_UID_BITS) begin
                            state_q <= uidpt_pkg::ST_IGNORE;   // R1
                        end else begin
                            cnt_q <= cnt_q + 8'h01;
                        end
                    end
                end

                uidpt_pkg::ST_PT_OUT: begin
                    // low three bits give the bit within the byte
                    // no end count: the host stops by deselect
                    if (sck_fall) begin
                        cnt_q <= {5'h00, cnt_q[2:0] + 3'h1};   // R6
                    end
                end

                uidpt_pkg::ST_IGNORE: begin
                    // wait for deselect
                    state_q <= uidpt_pkg::ST_IGNORE;
                end

                default: begin
                    // unused code: quiet until deselect
                    state_q <= uidpt_pkg::ST_IGNORE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // table address
    // ------------------------------------------------------------
    // the shift keeps only the low address bits, so any start byte
    // is taken and higher address bits alias onto the table
    // deselect keeps the index; a frame reloads it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tbl_idx_q <= '0;
        end else if (!selected) begin
            tbl_idx_q <= tbl_idx_q;
        end else if (state_q == uidpt_pkg::ST_ADDR && sck_rise) begin
            tbl_idx_q <= {tbl_idx_q[TABLE_AW-2:0], pins_sync_q.si};   // R4 R7
        end else if (state_q == uidpt_pkg::ST_PT_OUT && sck_fall
                     && cnt_q[2:0] == 3'h7) begin
            // last bit of the byte launched: step, wrapping at the top
            tbl_idx_q <= tbl_idx_q + 1'b1;   // R8 R9
        end
    end

    // ------------------------------------------------------------
    // table contents
    // ------------------------------------------------------------
    // unlisted bytes read as unused; no write path exists
    function automatic logic [7:0] table_lookup(input logic [7:0] a);
        logic [7:0] d;
        d = `UIDPT_UNUSED_BYTE;
        unique case (a)
            // signature and revisions
            8'h00: d = 8'h53;
            8'h01: d = 8'h46;
            8'h02: d = 8'h44;
            8'h03: d = 8'h50;
            8'h04: d = 8'h00;
            8'h05: d = 8'h01;
            8'h06: d = 8'h01;
            8'h07: d = `UIDPT_UNUSED_BYTE;   // R12

            // first header: standard table
            8'h08: d = `UIDPT_STD_ID;        // R15
            8'h09: d = 8'h00;
            8'h0A: d = 8'h01;
            8'h0B: d = `UIDPT_STD_LEN;       // R13
            8'h0C: d = `UIDPT_STD_PTR;       // R14
            8'h0D: d = 8'h00;
            8'h0E: d = 8'h00;
            8'h0F: d = `UIDPT_UNUSED_BYTE;   // R12

            // second header: vendor table
            8'h10: d = MAKER_ID;             // R16
            8'h11: d = 8'h00;
            8'h12: d = 8'h01;
            8'h13: d = `UIDPT_VND_LEN;       // R13
            8'h14: d = `UIDPT_VND_PTR;       // R14
            8'h15: d = 8'h00;
            8'h16: d = 8'h00;
            8'h17: d = `UIDPT_UNUSED_BYTE;   // R12

            // erase size, granularity, status volatility
            8'h30: d = {`UIDPT_BYTE30_UNUSED, `UIDPT_WREN_SEL, `UIDPT_VOLATILE_SR,
                        `UIDPT_WR_GRAN_64, `UIDPT_ERASE_4K};   // R17 R18 R19
            8'h31: d = 8'h20;
            8'h32: d = 8'hF1;

            // fast read descriptors
            8'h38: d = 8'h44;
            8'h39: d = 8'hEB;
            8'h3A: d = 8'h08;
            8'h3B: d = 8'h6B;
            8'h3C: d = 8'h08;
            8'h3D: d = 8'h3B;
            8'h3E: d = 8'h80;
            8'h3F: d = 8'hBB;
            8'h40: d = 8'hEE;
            8'h46: d = 8'h00;
            8'h4A: d = 8'h00;

            // sector sizes and erase codes
            8'h4C: d = 8'h0C;
            8'h4D: d = 8'h20;
            8'h4E: d = 8'h0F;
            8'h4F: d = 8'h52;
            8'h50: d = 8'h10;
            8'h51: d = 8'hD8;

            // the rest, vendor table included
            default: d = `UIDPT_UNUSED_BYTE;
        endcase
        return d;
    endfunction

    // the lookup settles well before the next fall
    // id is a parameter, so no command can alter it
    assign tbl_byte = table_lookup(8'(tbl_idx_q));   // R3

    // ------------------------------------------------------------
    // serial output
    // ------------------------------------------------------------
    // data changes only on host falling edges, two to three clocks
    // late; at the fastest serial clock the host gets at least one
    // clock of setup before its rise, so a slower system clock
    // breaks the read; the output is released outside data phases
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            so_q    <= 1'b0;
            so_oe_q <= 1'b0;
        end else if (!selected) begin
            so_q    <= 1'b0;
            so_oe_q <= 1'b0;   // R10 R22
        end else if (sck_fall) begin
            if (state_q == uidpt_pkg::ST_UID_OUT && cnt_q != `UIDPT_UID_BITS) begin
                // msb first: inverted count is 127 - count
                so_q    <= UNIQUE_ID[~cnt_q[6:0]];   // R2
                so_oe_q <= 1'b1;
            end else if (state_q == uidpt_pkg::ST_PT_OUT) begin
                so_q    <= tbl_byte[~cnt_q[2:0]];   // R6
                so_oe_q <= 1'b1;
            end else begin
                // past the id, or no data phase
                so_q    <= 1'b0;
                so_oe_q <= 1'b0;   // R22
            end
        end
    end

    // both outputs come straight from flops
    assign so    = so_q;
    assign so_oe = so_oe_q;

endmodule

// ---- testbench/uidpt_checker.sv ----
// concurrent checks for the unique id and parameter table query logic
// assumes it is bound to uidpt_top and that the host is clock-synchronous
`timescale 1ns/1ns
module uidpt_checker (
    // clock and reset
    input wire logic                   clk,
    input wire logic                   rstn,
    // watched ports
    input wire uidpt_pkg::uidpt_pins_t link_pins,
    input wire logic                   cycle_busy,
    input wire logic                   op_suspended,
    input wire logic                   so,
    input wire logic                   so_oe
);
    // ----------------------------------------------------------------
    // helper logic
    // ----------------------------------------------------------------
    logic       sck_prev_q; // serial clock at the previous edge
    logic [3:0] fall_age_q; // cycles since a serial clock fall, saturates
    logic [7:0] rise_cnt_q; // rises in this frame, saturates
    logic [7:0] op_q;       // first eight bits of the frame
    logic       refuse_q;   // busy and not suspended during the opcode

    // age of the last fall; raw pins suffice since the bench host is synchronous
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sck_prev_q <= 1'b0;
            fall_age_q <= 4'hF;
        end else begin
            sck_prev_q <= link_pins.sck;
            if (sck_prev_q && !link_pins.sck) begin
                fall_age_q <= 4'h1;
            end else if (fall_age_q != 4'hF) begin
                fall_age_q <= fall_age_q + 4'h1;
            end
        end
    end

    // frame decode, cleared while deselected
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rise_cnt_q <= 8'h00;
            op_q       <= 8'h00;
            refuse_q   <= 1'b0;
        end else if (link_pins.cs_n) begin
            rise_cnt_q <= 8'h00;
            op_q       <= 8'h00;
            refuse_q   <= 1'b0;
        end else begin
            if (rise_cnt_q < 8'h08) begin
                refuse_q <= cycle_busy && !op_suspended;
            end
            if (!sck_prev_q && link_pins.sck && rise_cnt_q != 8'hFF) begin
                rise_cnt_q <= rise_cnt_q + 8'h01;
                if (rise_cnt_q < 8'h08) begin
                    op_q <= {op_q[6:0], link_pins.si};
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_idle_quiet: assert property (@(posedge clk) disable iff (!rstn)
        link_pins.cs_n [*6] |-> !so_oe) else $error("output enabled while deselected");
    a_deselect_drop: assert property (@(posedge clk) disable iff (!rstn)
        $rose(link_pins.cs_n) |-> ##[1:5] !so_oe) else $error("output kept after deselect");
    a_released_low: assert property (@(posedge clk) disable iff (!rstn)
        !so_oe |-> !so) else $error("data high while released");
    a_start_timing: assert property (@(posedge clk) disable iff (!rstn)
        $rose(so_oe) |-> fall_age_q inside {4'h3, 4'h4}) else $error("output start off fall");
    a_bit_timing: assert property (@(posedge clk) disable iff (!rstn)
        so_oe && $past(so_oe) && $changed(so) |-> fall_age_q inside {4'h3, 4'h4})
        else $error("data changed away from a falling edge");
    a_header_quiet: assert property (@(posedge clk) disable iff (!rstn)
        rise_cnt_q != 8'h00 && rise_cnt_q < 8'h28 |-> !so_oe)
        else $error("output during opcode, address or dummy");
    a_bad_op_quiet: assert property (@(posedge clk) disable iff (!rstn)
        rise_cnt_q >= 8'h08 && op_q != 8'h4B && op_q != 8'h5A |-> !so_oe)
        else $error("unknown opcode answered");
    a_busy_refused: assert property (@(posedge clk) disable iff (!rstn)
        rise_cnt_q >= 8'h08 && op_q == 8'h5A && refuse_q |-> !so_oe)
        else $error("table read answered while busy");
    a_uid_release: assert property (@(posedge clk) disable iff (!rstn)
        rise_cnt_q >= 8'hA9 && op_q == 8'h4B |-> !so_oe) else $error("id output too long");
endmodule

bind uidpt_top uidpt_checker chk_u (.clk(clk), .rstn(rstn), .link_pins(link_pins),
    .cycle_busy(cycle_busy), .op_suspended(op_suspended), .so(so), .so_oe(so_oe));

// ---- testbench/uidpt_host_model.sv ----
// serial host model that drives the link pins of the query logic
// assumes mode 0 (clock idle low) and the 100 MHz bench clock
`timescale 1ns/1ns
module uidpt_host_model (
    // bench clock
    input wire logic               clk,
    // link towards the device
    output uidpt_pkg::uidpt_pins_t pins,
    input wire logic               so,
    input wire logic               so_oe
);
    logic oe_seen; // output enable seen during this frame
    logic oe_last; // output enable at the latest sample

    // start deselected with the clock low
    initial begin
        pins    = 3'h4;
        oe_seen = 1'b0;
        oe_last = 1'b0;
    end

    // select; the device needs two clocks of sync latency before a rise
    task automatic select_dev();
        @(posedge clk);
        pins.cs_n <= 1'b0;
        oe_seen = 1'b0;
        repeat (3) @(posedge clk);
    endtask

    // one byte msb first, 80 ns per bit; data moves on the fall
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            @(posedge clk);
            pins.sck <= 1'b0;
            pins.si  <= tx[i];
            repeat (4) @(posedge clk);
            pins.sck <= 1'b1;
            #1;
            rx[i]   = so_oe ? so : 1'bx;
            oe_last = so_oe;
            oe_seen = oe_seen | so_oe;
            repeat (3) @(posedge clk);
        end
    endtask

    // deselect; si is driven to the inverse of its last level as chip select rises
    task automatic deselect_dev();
        @(posedge clk);
        pins.sck <= 1'b0;
        repeat (4) @(posedge clk);
        pins.cs_n <= 1'b1;
        pins.si   <= ~pins.si;
        repeat (6) @(posedge clk);
    endtask
endmodule

// ---- testbench/test_uidpt_top.sv ----
// self-checking bench for the unique id and parameter table query logic
// assumes the host model and the bound checker are compiled beforehand
`timescale 1ns/1ns
module test_uidpt_top;
    // arbitrary stand-ins for the factory id and the maker code
    localparam logic [127:0] UID_V   = 128'h1234_5678_9ABC_DEF0_0F0E_0D0C_0B0A_0908;
    localparam logic [7:0]   MAKER_V = 8'h3C;
    // header bytes 00H to 17H
    localparam logic [0:23][7:0] HDR_V = {8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01,
        8'hFF, 8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hFF, MAKER_V, 8'h00,
        8'h01, 8'h03, 8'h60, 8'h00, 8'h00, 8'hFF};

    logic                   clk;             // system clock
    logic                   rstn;            // async reset
    logic                   cycle_busy;      // array cycle running
    logic                   op_suspended;    // array cycle suspended
    uidpt_pkg::uidpt_pins_t pins;            // link pins from the host
    logic                   so;              // serial data out
    logic                   so_oe;           // its enable
    int                     err_count;       // mismatches
    int                     samples_checked; // comparisons

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    uidpt_top #(.UNIQUE_ID(UID_V), .MAKER_ID(MAKER_V)) dut_u (.clk(clk), .rstn(rstn),
        .link_pins(pins), .cycle_busy(cycle_busy), .op_suspended(op_suspended),
        .so(so), .so_oe(so_oe));
    uidpt_host_model host_u (.clk(clk), .pins(pins), .so(so), .so_oe(so_oe));

    // shared compare, counts and reports
    task automatic check(input logic [127:0] got, input logic [127:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t %s: got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    // expected table byte; only listed bytes and FFH fillers are used
    function automatic logic [7:0] exp_byte(input logic [6:0] a);
        if (a < 7'h18) begin
            return HDR_V[a];
        end
        return (a == 7'h30) ? 8'hE5 : 8'hFF;
    endfunction

    // id read, checked whole and for release afterwards
    task automatic t_uid();
        logic [7:0]   rx;
        logic [127:0] id;
        host_u.select_dev();
        host_u.xfer(8'h4B, rx);
        repeat (4) host_u.xfer(8'h00, rx);
        for (int i = 0; i < 16; i++) begin
            host_u.xfer(8'h00, rx);
            id = {id[119:0], rx};
        end
        host_u.xfer(8'h00, rx);
        host_u.deselect_dev();
        check(id, UID_V, "unique id");
        check(host_u.oe_last, 1'b0, "output kept after id");
        $display("test unique id done");
    endtask

    // table read of n bytes from start
    task automatic t_table(input logic [6:0] start, input int n);
        logic [7:0] rx;
        host_u.select_dev();
        host_u.xfer(8'h5A, rx);
        host_u.xfer(8'h00, rx);
        host_u.xfer(8'h00, rx);
        host_u.xfer({1'b0, start}, rx);
        host_u.xfer(8'h00, rx);
        for (int i = 0; i < n; i++) begin
            host_u.xfer(8'hFF, rx);
            check(rx, exp_byte(start + 7'(i)), "table byte");
        end
        host_u.deselect_dev();
        check(so_oe, 1'b0, "output kept after deselect");
        $display("test table from %0h done", start);
    endtask

    // frame that must never drive the output
    task automatic t_quiet(input logic [7:0] op, input int n);
        logic [7:0] rx;
        host_u.select_dev();
        host_u.xfer(op, rx);
        repeat (n) host_u.xfer(8'h00, rx);
        host_u.deselect_dev();
        check(host_u.oe_seen, 1'b0, "quiet frame drove output");
        $display("test quiet frame %0h done", op);
    endtask

    // verdict, the single place the run ends
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        repeat (100000) @(posedge clk);
        err_count++;
        conclude();
    end

    // main sequence
    initial begin
        rstn            = 1'b0;
        cycle_busy      = 1'b0;
        op_suspended    = 1'b0;
        err_count       = 0;
        samples_checked = 0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        t_uid();
        t_uid();
        t_table(7'h00, 49);
        t_table(7'h7F, 3);
        t_quiet(8'h9F, 6);
        t_quiet(8'h5A, 1);
        t_table(7'h0B, 2);
        @(posedge clk) cycle_busy <= 1'b1;
        t_quiet(8'h5A, 6);
        @(posedge clk) op_suspended <= 1'b1;
        t_table(7'h2E, 3);
        conclude();
    end
endmodule
